// ==== rtl/spt_top.sv ====
/*
 spt_top: step period measurement, threshold gating of driver features,
 AXI4-Lite register slave and a masked level interrupt.
 Assumes step_pulse and standstill come synchronous to aclk from the ramp logic.
*/
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - measure cycles between 1/256 microsteps, readable as 20-bit value
// - overflow or standstill reports all ones
// - threshold compares use hysteresis of one sixteenth
// - reduced-hysteresis flag selects one thirty-second
// - second compare value is threshold times 15/16 or 31/32 minus one
// - lower switch point at threshold, upper higher by hysteresis
// - steady steps at rate give period within one count of spacing
// - slow of pwm threshold: pwm mode allowed, constant-velocity stall off
// - cool threshold is lower velocity limit for adaptive current and stall
// - adaptive current only between cool and high-velocity thresholds
// - stop-on-stall armed only at or below cool threshold, or held past it in constant-velocity mode once reached
// - stall on diagnostic outputs only at or below cool threshold, or held past it in constant-velocity mode once reached
// - outside constant-velocity mode, stall functions drop below cool velocity
// - at or below high threshold: adaptive current and pwm mode off
module spt_top
   import spt_pkg::*;
#(
   parameter int W = PERIOD_W
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  step_pulse,
   input  wire logic                  standstill,
   output spt_gate_t                  gates,
   output logic                       irq
);
   localparam logic [31-W:0] PAD = '0;

   // register state
   logic [W-1:0]        pwm_thr_reg;
   logic [W-1:0]        cool_thr_reg;
   logic [W-1:0]        high_thr_reg;
   spt_ctrl_t           ctrl_reg;
   spt_zone_t           irq_stat_reg;
   spt_zone_t           irq_mask_reg;
   spt_zone_t           zone_prev_reg;
   spt_gate_t           gates_reg;
   logic                stall_hold_reg;
   // bus state
   logic                aw_got_reg;
   logic                w_got_reg;
   logic [IDX_W-1:0]    wr_idx_reg;
   logic [31:0]         wdata_reg;
   logic [3:0]          wstrb_reg;
   logic                bvalid_reg;
   logic [1:0]          bresp_reg;
   logic                rvalid_reg;
   logic [31:0]         rdata_reg;
   logic [1:0]          rresp_reg;
   // measurement and zones
   logic [W-1:0]        period;
   spt_zone_t           zone;
   logic                wr_do;
   spt_gate_t           gates_next;
   logic                const_active;
   logic                stall_zone;
   spt_zone_t           irq_evt;
   spt_zone_t           irq_clr;

   // merge a write word into a register under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction : merge

   // mapped word index test shared by read and write decode
   function automatic logic mapped(input logic [IDX_W-1:0] idx);
      return (idx >= IDX_PERIOD) && (idx <= IDX_IRQ_MASK);
   endfunction : mapped

   spt_period_meter #(.W(W)) u_meter (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .step_pulse (step_pulse),
      .standstill (standstill),
      .period     (period),
      .saturated  (zone.saturated)
   );

   spt_hyst_cmp #(.W(W)) u_cmp_pwm (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .period     (period),
      .threshold  (pwm_thr_reg),
      .small_hyst (ctrl_reg.small_hysteresis),
      .fast       (zone.pwm_fast)
   );

   spt_hyst_cmp #(.W(W)) u_cmp_cool (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .period     (period),
      .threshold  (cool_thr_reg),
      .small_hyst (ctrl_reg.small_hysteresis),
      .fast       (zone.cool_fast)
   );

   spt_hyst_cmp #(.W(W)) u_cmp_high (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .period     (period),
      .threshold  (high_thr_reg),
      .small_hyst (ctrl_reg.small_hysteresis),
      .fast       (zone.high_fast)
   );

   // feature gating from zone state
   assign const_active = ctrl_reg.const_vel_mode && zone.pwm_fast;
   assign stall_zone   = zone.cool_fast || (const_active && stall_hold_reg);
   always_comb begin
      gates_next                       = '0;
      gates_next.pwm_mode_en           = ctrl_reg.pwm_mode_cfg && !zone.pwm_fast
                                         && !zone.high_fast;
      gates_next.const_vel_stall_en    = const_active;
      gates_next.adaptive_current_en   = ctrl_reg.adaptive_cfg && zone.cool_fast
                                         && !zone.high_fast;
      gates_next.stall_stop_armed      = ctrl_reg.stall_stop_enable
                                         && ctrl_reg.internal_motion && stall_zone;
      gates_next.diagnostic_outputs_en = ctrl_reg.diag_stall_cfg && stall_zone;
   end

   // stall functions may stay on in constant-velocity mode once reached
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stall_hold_reg <= 1'b0;
         gates_reg      <= '0;
      end else begin
         stall_hold_reg <= stall_zone;
         gates_reg      <= gates_next;
      end
   end
   assign gates = gates_reg;

   // write channel: address and data taken in either order
   assign s_axi_awready = !aw_got_reg && !bvalid_reg;
   assign s_axi_wready  = !w_got_reg && !bvalid_reg;
   assign wr_do         = aw_got_reg && w_got_reg && !bvalid_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_reg <= 1'b0;
         w_got_reg  <= 1'b0;
         wr_idx_reg <= '0;
         wdata_reg  <= '0;
         wstrb_reg  <= '0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            wr_idx_reg <= s_axi_awaddr[AXI_ADDR_W-1:2];
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (wr_do) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg  <= mapped(wr_idx_reg) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   // writable registers; read-only words ignore writes but answer okay
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwm_thr_reg  <= THR_RESET;
         cool_thr_reg <= THR_RESET;
         high_thr_reg <= THR_RESET;
         ctrl_reg     <= CTRL_RESET;
         irq_mask_reg <= IRQ_RESET;
      end else if (wr_do) begin
         unique case (wr_idx_reg)
            IDX_PWM_THR:  pwm_thr_reg  <= W'(merge({PAD, pwm_thr_reg}, wdata_reg, wstrb_reg));
            IDX_COOL_THR: cool_thr_reg <= W'(merge({PAD, cool_thr_reg}, wdata_reg, wstrb_reg));
            IDX_HIGH_THR: high_thr_reg <= W'(merge({PAD, high_thr_reg}, wdata_reg, wstrb_reg));
            IDX_CTRL:     ctrl_reg     <= 7'(merge({25'h0, ctrl_reg}, wdata_reg, wstrb_reg));
            IDX_IRQ_MASK: irq_mask_reg <= 4'(merge({28'h0, irq_mask_reg}, wdata_reg, wstrb_reg));
            default:      ;
         endcase
      end
   end

   // zone edges are sticky events; a new event beats a same-cycle clear
   assign irq_evt = zone ^ zone_prev_reg;
   assign irq_clr = (wr_do && wr_idx_reg == IDX_IRQ_STAT && wstrb_reg[0])
                    ? spt_zone_t'(wdata_reg[3:0]) : spt_zone_t'(4'h0);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         zone_prev_reg <= IRQ_RESET;
         irq_stat_reg  <= IRQ_RESET;
      end else begin
         zone_prev_reg <= zone;
         irq_stat_reg  <= (irq_stat_reg & ~irq_clr) | irq_evt;
      end
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   // read channel: one word per request, data registered
   assign s_axi_arready = !rvalid_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rresp_reg  <= mapped(s_axi_araddr[AXI_ADDR_W-1:2]) ? RESP_OKAY : RESP_SLVERR;
         unique case (s_axi_araddr[AXI_ADDR_W-1:2])
            IDX_PERIOD:   rdata_reg <= {PAD, period};
            IDX_PWM_THR:  rdata_reg <= {PAD, pwm_thr_reg};
            IDX_COOL_THR: rdata_reg <= {PAD, cool_thr_reg};
            IDX_HIGH_THR: rdata_reg <= {PAD, high_thr_reg};
            IDX_CTRL:     rdata_reg <= {25'h0, ctrl_reg};
            IDX_ZONE:     rdata_reg <= {23'h0, gates_reg, zone};
            IDX_IRQ_STAT: rdata_reg <= {28'h0, irq_stat_reg};
            IDX_IRQ_MASK: rdata_reg <= {28'h0, irq_mask_reg};
            default:      rdata_reg <= '0;
         endcase
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

   a_pwm_allow: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl_reg.pwm_mode_cfg && !zone.pwm_fast && !zone.high_fast) |=> gates.pwm_mode_en)
      else $error("pwm mode not allowed when slow");
   a_cvs_off: assert property (@(posedge aclk) disable iff (!aresetn)
      !zone.pwm_fast |=> !gates.const_vel_stall_en)
      else $error("constant velocity stall on while slow");
   a_adapt_band: assert property (@(posedge aclk) disable iff (!aresetn)
      gates.adaptive_current_en |-> $past(zone.cool_fast) && !$past(zone.high_fast))
      else $error("adaptive current outside band");
   a_high_off: assert property (@(posedge aclk) disable iff (!aresetn)
      zone.high_fast |=> !gates.adaptive_current_en && !gates.pwm_mode_en)
      else $error("features on above high threshold");
   a_stop_arm: assert property (@(posedge aclk) disable iff (!aresetn)
      (zone.cool_fast && ctrl_reg.stall_stop_enable && ctrl_reg.internal_motion)
      |=> gates.stall_stop_armed)
      else $error("stop on stall not armed");
   a_diag_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      (zone.cool_fast && ctrl_reg.diag_stall_cfg) |=> gates.diagnostic_outputs_en)
      else $error("stall output not enabled");
   a_stall_drop: assert property (@(posedge aclk) disable iff (!aresetn)
      (!zone.cool_fast && !ctrl_reg.const_vel_mode)
      |=> !gates.stall_stop_armed && !gates.diagnostic_outputs_en)
      else $error("stall functions kept below cool velocity");
   a_irq_set_win: assert property (@(posedge aclk) disable iff (!aresetn)
      (irq_evt != 4'h0) |=> ((irq_stat_reg & $past(irq_evt)) == $past(irq_evt)))
      else $error("zone event lost");
   c_wr_rd: cover property (@(posedge aclk) disable iff (!aresetn)
      wr_do ##[1:8] (s_axi_rvalid && s_axi_rready));
   c_adapt: cover property (@(posedge aclk) disable iff (!aresetn)
      gates.adaptive_current_en ##[1:100] gates.pwm_mode_en);
   c_cvs_hold: cover property (@(posedge aclk) disable iff (!aresetn)
      gates.const_vel_stall_en && !zone.cool_fast && gates.stall_stop_armed);
   c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
endmodule : spt_top
`default_nettype wire

// ==== rtl/spt_pkg.sv ====
/*
 spt_pkg: constants and carrier types of the step period threshold block.
 Assumes a single 250 MHz clock domain and word-aligned AXI4-Lite register access.
*/
package spt_pkg;
   // period measurement
   localparam int          PERIOD_W     = 20;
   localparam logic [19:0] PERIOD_MAX   = 20'hfffff;
   localparam logic [19:0] THR_RESET    = 20'h00000;
   // hysteresis fractions: numerator and shift
   localparam int          HYST_NUM_STD = 15;
   localparam int          HYST_SH_STD  = 4;
   localparam int          HYST_NUM_SML = 31;
   localparam int          HYST_SH_SML  = 5;
   // register word indices; byte address is index * 4
   localparam int          AXI_ADDR_W   = 8;
   localparam int          IDX_W        = 6;
   localparam logic [5:0]  IDX_PERIOD   = 6'h12;
   localparam logic [5:0]  IDX_PWM_THR  = 6'h13;
   localparam logic [5:0]  IDX_COOL_THR = 6'h14;
   localparam logic [5:0]  IDX_HIGH_THR = 6'h15;
   localparam logic [5:0]  IDX_CTRL     = 6'h16;
   localparam logic [5:0]  IDX_ZONE     = 6'h17;
   localparam logic [5:0]  IDX_IRQ_STAT = 6'h18;
   localparam logic [5:0]  IDX_IRQ_MASK = 6'h19;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   localparam logic [6:0]  CTRL_RESET   = 7'h00;
   localparam logic [3:0]  IRQ_RESET    = 4'h0;

   // control register, bit 6 first, down to bit 0 at the bottom
   typedef struct packed {
      logic const_vel_mode;
      logic internal_motion;
      logic diag_stall_cfg;
      logic stall_stop_enable;
      logic adaptive_cfg;
      logic pwm_mode_cfg;
      logic small_hysteresis;
   } spt_ctrl_t;

   // zone state; also the layout of the interrupt status and mask
   typedef struct packed {
      logic saturated;
      logic high_fast;
      logic cool_fast;
      logic pwm_fast;
   } spt_zone_t;

   // feature gates driven to the driver stages
   typedef struct packed {
      logic pwm_mode_en;
      logic const_vel_stall_en;
      logic adaptive_current_en;
      logic stall_stop_armed;
      logic diagnostic_outputs_en;
   } spt_gate_t;
endpackage : spt_pkg

// ==== rtl/spt_period_meter.sv ====
/*
 spt_period_meter: counts clock cycles between microstep pulses.
 Assumes step_pulse is a one-cycle pulse per 1/256 microstep, synchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module spt_period_meter
   import spt_pkg::*;
#(
   parameter int W = PERIOD_W
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         step_pulse,
   input  wire logic         standstill,
   output logic [W-1:0]      period,
   output logic              saturated
);
   logic [W-1:0] cnt_reg;
   logic [W-1:0] period_reg;
   localparam logic [W-1:0] ALL_ONES = '1;

   // free counter, restarts at one on each step, saturates at all ones
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= ALL_ONES;
      end else if (step_pulse) begin
         cnt_reg <= W'(1);
      end else if (cnt_reg != ALL_ONES) begin
         cnt_reg <= cnt_reg + W'(1);
      end
   end

   // capture on step; overflow or standstill reads all ones
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         period_reg <= THR_RESET;
      end else if (standstill || (cnt_reg == ALL_ONES && !step_pulse)) begin
         period_reg <= ALL_ONES;
      end else if (step_pulse) begin
         period_reg <= cnt_reg;
      end
   end

   assign period    = period_reg;
   assign saturated = (period_reg == ALL_ONES);

   a_step_capture: assert property (@(posedge aclk) disable iff (!aresetn)
      (step_pulse && !standstill && cnt_reg != ALL_ONES) |=> period == $past(cnt_reg))
      else $error("period not captured on step");
   a_stand_max: assert property (@(posedge aclk) disable iff (!aresetn)
      standstill |=> period == ALL_ONES)
      else $error("standstill period not all ones");
   a_steady_rate: assert property (@(posedge aclk) disable iff (!aresetn)
      (step_pulse ##1 (!step_pulse && !standstill)[*7] ##1 (step_pulse && !standstill))
      |=> period == W'(8))
      else $error("period off for eight cycle step rate");
   c_overflow: cover property (@(posedge aclk) disable iff (!aresetn)
      !standstill && cnt_reg == ALL_ONES);
endmodule : spt_period_meter
`default_nettype wire

// ==== rtl/spt_hyst_cmp.sv ====
/*
 spt_hyst_cmp: one threshold comparison with hysteresis and its own state bit.
 Assumes period and threshold are stable register values in the aclk domain.
*/
`timescale 1ns/100ps
`default_nettype none
module spt_hyst_cmp
   import spt_pkg::*;
#(
   parameter int W = PERIOD_W
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] period,
   input  wire logic [W-1:0] threshold,
   input  wire logic         small_hyst,
   output logic              fast
);
   localparam int PW = W + 5;

   // threshold * 15/16 - 1 or * 31/32 - 1; msb set means negative
   function automatic logic [W:0] second_cmp(input logic [W-1:0] thr, input logic sml);
      logic [PW-1:0] prod;
      prod = sml ? (({5'h00, thr} * PW'(HYST_NUM_SML)) >> HYST_SH_SML)
                 : (({5'h00, thr} * PW'(HYST_NUM_STD)) >> HYST_SH_STD);
      return {1'b0, prod[W-1:0]} - {{W{1'b0}}, 1'b1};
   endfunction : second_cmp

   logic [W:0] lo;
   logic       set_cond;
   logic       clr_cond;
   logic       fast_reg;

   assign lo       = second_cmp(threshold, small_hyst);
   assign set_cond = !lo[W] && ({1'b0, period} <= lo);
   assign clr_cond = period > threshold;

   // on above threshold plus hysteresis, off only below the threshold itself
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fast_reg <= 1'b0;
      end else if (set_cond) begin
         fast_reg <= 1'b1;
      end else if (clr_cond) begin
         fast_reg <= 1'b0;
      end
   end
   assign fast = fast_reg;

   a_on_upper: assert property (@(posedge aclk) disable iff (!aresetn)
      (!small_hyst && threshold == W'(64) && period == W'(59)) |=> fast)
      else $error("no switch on at 15/16 point");
   a_no_early: assert property (@(posedge aclk) disable iff (!aresetn)
      (!small_hyst && threshold == W'(64) && period == W'(60) && !fast) |=> !fast)
      else $error("switched on inside hysteresis band");
   a_small_hyst: assert property (@(posedge aclk) disable iff (!aresetn)
      (small_hyst && threshold == W'(64) && period == W'(61)) |=> fast)
      else $error("small hysteresis not applied");
   a_off_lower: assert property (@(posedge aclk) disable iff (!aresetn)
      (period > threshold && !set_cond) |=> !fast)
      else $error("no switch off below threshold");
   a_band_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (fast && period == threshold) |=> fast)
      else $error("state lost at threshold");
endmodule : spt_hyst_cmp
`default_nettype wire

// ==== bench/spt_step_gen.sv ====
/*
 spt_step_gen: ramp side model, issues one-cycle microstep pulses at a set spacing.
 Assumes the bench changes gap and run just after a rising aclk edge.
*/
`timescale 1ns/100ps
`default_nettype none
module spt_step_gen (
   input  wire logic        aclk,
   input  wire logic        run,
   input  wire logic [19:0] gap,
   output logic             step_pulse,
   output logic             standstill
);
   logic [19:0] cnt_reg;
   // one pulse every gap cycles; a gap change may give one odd interval
   always_ff @(posedge aclk) begin
      if (run && cnt_reg >= gap - 20'h00001) begin
         step_pulse <= 1'b1;
         cnt_reg    <= 20'h00000;
      end else begin
         step_pulse <= 1'b0;
         cnt_reg    <= run ? cnt_reg + 20'h00001 : 20'h00000;
      end
   end
   // no pulses while stopped, so standstill is just the inverse
   assign standstill = !run;
endmodule : spt_step_gen
`default_nettype wire

// ==== bench/spt_top_bench.sv ====
/*
 spt_top_bench: self-checking bench of the step period threshold block.
 Assumes the AXI4-Lite timing and register map handed over for spt_top.
*/
`timescale 1ns/100ps
`default_nettype none
module spt_top_bench;
   import spt_pkg::*;
   typedef struct packed {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;} spt_exp_t;
   logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, run = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, seed = 32'h94aaf163;
   logic [19:0] gap = 20'h00001;
   logic        awready, wready, bvalid, arready, rvalid, step_pulse, standstill, irq;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   spt_gate_t   gates;
   spt_exp_t    exp_q[$];
   spt_exp_t    e;
   int          mismatches = 0, tests_run = 0;
   logic [19:0] gl [9] = '{20'h28, 20'h41, 20'h3c, 20'h3b, 20'h40, 20'h41, 20'h3d, 20'h3e, 20'h41};
   logic [8:0]  cool = 9'h0d9;

   spt_top spt_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .step_pulse(step_pulse),
      .standstill(standstill), .gates(gates), .irq(irq));
   spt_step_gen spt_step_gen_inst (.aclk(aclk), .run(run), .gap(gap),
      .step_pulse(step_pulse), .standstill(standstill));

   // 250 MHz
   always #2 aclk = ~aclk;

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task check_word(input logic [31:0] d, input logic [1:0] r, input spt_exp_t x);
      tests_run++;
      if ((d & x.mask) !== (x.data & x.mask) || r !== x.resp) begin
         mismatches++;
         $display("wrong value at %0t: bus answer %h/%h, want %h/%h", $time, d, r, x.data, x.resp);
      end
   endtask : check_word

   // callers sample at a falling edge, so the launching edge's updates have landed
   task check_bits(input logic [4:0] got, input logic [4:0] want);
      tests_run++;
      if (got !== want) begin
         mismatches++;
         $display("wrong value at %0t: level outputs %h, want %h", $time, got, want);
      end
   endtask : check_bits

   // ready is sampled at the falling edge, where it cannot race the rising one
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      logic aw, w;
      @(posedge aclk);
      exp_q.push_back('{32'h0, 32'h0, r});
      aw = 1'b0;
      w = 1'b0;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      {awvalid, wvalid} <= 2'b11;
      while (!(aw && w)) begin
         @(negedge aclk);
         aw = aw | awready;
         w = w | wready;
         @(posedge aclk);
         {awvalid, wvalid} <= {!aw, !w};
      end
      @(negedge aclk);
      while (!bvalid) @(negedge aclk);
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
      @(posedge aclk);
      exp_q.push_back('{d, m, r});
      araddr <= a;
      {arvalid, rready} <= 2'b11;
      @(negedge aclk);
      while (!arready) @(negedge aclk);
      @(posedge aclk);
      arvalid <= 1'b0;
      @(negedge aclk);
      while (!rvalid) @(negedge aclk);
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rd

   // new spacing, then three full intervals plus the zone and gate stages
   task step_at(input logic [19:0] g, input logic go);
      @(posedge aclk);
      gap <= g;
      run <= go;
      repeat (3 * g + 12) @(posedge aclk);
   endtask : step_at

   task zone(input logic [3:0] z, input logic [4:0] g);
      rd(8'h5c, {23'h0, g, z}, 32'hffffffff, RESP_OKAY);
      @(negedge aclk) check_bits(gates, g);
   endtask : zone

   // response monitor: one answer, one oldest note
   always @(negedge aclk) begin
      if ((bvalid && bready) || (rvalid && rready)) begin
         e = exp_q.pop_front();
         check_word(rvalid ? rdata : 32'h0, rvalid ? rresp : bresp, e);
      end
   end

   task results;
      $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results

   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 4; i++) rd(8'h4c + 8'(4*i), 32'h0, 32'hffffffff, RESP_OKAY);
      rd(8'h64, 32'h0, 32'hffffffff, RESP_OKAY);
      rd(8'h48, 32'h000fffff, 32'hffffffff, RESP_OKAY);
      wr(8'h48, 32'h00000005, RESP_OKAY);
      rd(8'h48, 32'h000fffff, 32'hffffffff, RESP_OKAY);
      wr(8'h00, 32'h00000001, RESP_SLVERR);
      rd(8'h00, 32'h0, 32'hffffffff, RESP_SLVERR);
      seed = lfsr(seed);
      wr(8'h4c, seed, RESP_OKAY);
      rd(8'h4c, {12'h000, seed[19:0]}, 32'hffffffff, RESP_OKAY);
      wr(8'h4c, 32'h0, RESP_OKAY);
      wr(8'h50, 32'h00000040, RESP_OKAY);
      wr(8'h58, 32'h0000003e, RESP_OKAY);
      wr(8'h64, 32'h0000000f, RESP_OKAY);
      // cool threshold 64: on at 59 (61 with small hysteresis), off above 64
      for (int i = 0; i < 9; i++) begin
         if (i == 6) wr(8'h58, 32'h0000003f, RESP_OKAY);
         step_at(gl[i], 1'b1);
         rd(8'h48, {12'h000, gl[i]}, 32'hffffffff, RESP_OKAY);
         zone({2'b00, cool[i], 1'b0}, cool[i] ? 5'h17 : 5'h10);
      end
      wr(8'h54, 32'h00000040, RESP_OKAY);
      step_at(20'h00032, 1'b1);
      zone(4'h6, 5'h03);
      step_at(20'h00001, 1'b0);
      zone(4'h8, 5'h10);
      @(negedge aclk) check_bits({4'h0, irq}, 5'h01);
      wr(8'h60, 32'hffffffff, RESP_OKAY);
      @(negedge aclk) check_bits({4'h0, irq}, 5'h00);
      rd(8'h60, 32'h0, 32'hffffffff, RESP_OKAY);
      wr(8'h64, 32'h0, RESP_OKAY);
      step_at(20'h00028, 1'b1);
      @(negedge aclk) check_bits({4'h0, irq}, 5'h00);
      rd(8'h60, 32'h00000008, 32'h00000008, RESP_OKAY);
      // constant-velocity mode: pwm zone on, stall functions held past the cool point
      wr(8'h54, 32'h0, RESP_OKAY);
      wr(8'h4c, 32'h00000080, RESP_OKAY);
      wr(8'h58, 32'h0000007f, RESP_OKAY);
      step_at(20'h00028, 1'b1);
      zone(4'h3, 5'h0f);
      step_at(20'h00041, 1'b1);
      zone(4'h1, 5'h0b);
      // eight cycle spacing, the rate the steady-rate check watches
      step_at(20'h00008, 1'b1);
      rd(8'h48, 32'h00000008, 32'hffffffff, RESP_OKAY);
      results;
   end

   // watchdog, far beyond the few thousand cycles the sequence needs
   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      results;
   end
endmodule : spt_top_bench
`default_nettype wire
